// ### bench/test_tlcd_top.sv
// Self-checking bench for the test loop command decoder
`timescale 1ns/1ns
`default_nettype none
module test_tlcd_top;
    logic hclk = 0, hresetn = 0, hwrite = 0, test_sim_present = 0, link_ready = 0;
    logic audio_port_strobe = 0, hreadyout, hresp, rx_valid, rx_last, rx_ready;
    logic tx_valid, tx_last, tx_ready, maintenance_test_link, flow_on_msg, audio_test_active;
    logic traffic_loop_closed, traffic_subch, ms_loop_closed, slot_number_valid, ms_error;
    logic [1:0] htrans = 0, coding_select;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [7:0] rx_data, tx_data;
    logic [2:0] audio_port_device = 0, audio_device, ms_mech, slot_number;
    tlcd_pkg::tlcd_loop_e loop_kind;
    int n_fail = 0, n_checks = 0, n_flow = 0;
    tlcd_top u_tlcd_top (.ce(1'b1), .hsel(1'b1), .hsize(3'h2), .hready(hreadyout), .*);
    tlcd_tester u_tlcd_tester (.*);
    always #50 hclk = ~hclk;
    always @(posedge hclk) if (flow_on_msg === 1'b1) n_flow++;
    task automatic chk(input string n, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", n, e, g);
            n_fail++;
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic cmd(input logic [23:0] m, input int n, input logic [23:0] a, input int na);
        u_tlcd_tester.got.delete();
        u_tlcd_tester.send(m, n);
        for (int i = 0; i < 40 && u_tlcd_tester.got.size() < na; i++) @(posedge hclk);
        repeat (6) @(posedge hclk);
        chk("ack length", na, u_tlcd_tester.got.size());
        for (int i = 0; i < na; i++) chk("ack octet", a[23-8*i -: 8], u_tlcd_tester.got[i]);
    endtask
    task automatic lnk(input logic e);
        repeat (5) @(posedge hclk);
        chk("link", e, maintenance_test_link);
    endtask
    task automatic t_regs;
        logic [31:0] r;
        ahb(0, tlcd_pkg::REG_STATUS, 0, r);
        chk("status", 32'(tlcd_pkg::LOOP_NONE) << tlcd_pkg::ST_KIND_LSB, r);
        ahb(0, tlcd_pkg::REG_CTRL, 0, r);
        chk("ctrl", 32'h2, r);
        ahb(1, 32'h0c, 32'hffffffff, r);
        ahb(0, 32'h0c, 0, r);
        chk("unmapped", 0, r);
        $display("regs done");
    endtask
    task automatic t_link;
        logic [31:0] r;
        test_sim_present <= 1'b1;
        lnk(1);
        chk("flow", 0, n_flow);
        link_ready <= 1'b1;
        lnk(1);
        chk("flow", 1, n_flow);
        cmd(24'h0f1000, 2, 0, 0);
        lnk(0);
        cmd(24'h0f0c00, 2, 24'h0f0d00, 2);
        lnk(1);
        test_sim_present <= 1'b0;
        lnk(0);
        test_sim_present <= 1'b1;
        lnk(1);
        ahb(1, tlcd_pkg::REG_CTRL, 0, r);
        lnk(0);
        ahb(1, tlcd_pkg::REG_CTRL, 2, r);
        lnk(1);
        chk("flow", 4, n_flow);
        $display("link done");
    endtask
    task automatic t_drop;
        logic [31:0] r0, r;
        ahb(0, tlcd_pkg::REG_DROPS, 0, r0);
        cmd(24'h1f0000, 3, 0, 0);
        cmd(24'h0e0000, 3, 0, 0);
        cmd(24'h0f4000, 3, 0, 0);
        cmd(24'h0f0100, 2, 0, 0);
        ahb(0, tlcd_pkg::REG_DROPS, 0, r);
        chk("drops", r0 + 4, r);
        chk("loop", 0, traffic_loop_closed);
        $display("drop done");
    endtask
    task automatic t_loops;
        logic [7:0] a[7] = '{8'h00, 8'h02, 8'h06, 8'h0e, 8'h14, 8'h18, 8'h3f};
        for (int k = 0; k < 7; k++) begin
            u_tlcd_tester.slow = k[0];
            cmd({16'h0f00, a[k]}, 3, 24'h0f0100, 2);
            chk("kind", k, loop_kind);
            chk("subch", a[k][0], traffic_subch);
        end
        cmd(24'h0f0681, 3, 24'h0f0700, 2);
        chk("loop", 0, traffic_loop_closed);
        cmd(24'h0f0000, 3, 24'h0f0100, 2);
        cmd(24'h0f0600, 2, 0, 0);
        chk("loop", 0, traffic_loop_closed);
        $display("loops done");
    endtask
    task automatic t_multi;
        logic [7:0] a[4] = '{8'ha0, 8'h65, 8'h08, 8'h02};
        logic [7:0] g;
        logic e;
        for (int k = 0; k < 4; k++) begin
            e = a[k][4:2] > 1 || a[k][1:0] > 1;
            g = a[k > 1 ? 1 : k];
            cmd({16'h0f20, a[k]}, 3, {16'h0f21, a[k][4:0], 2'h0, e}, 3);
            chk("error", e, ms_error);
            chk("coding", g[1:0], coding_select);
            chk("mech", g[4:2], ms_mech);
            chk("slot valid", k == 0, slot_number_valid);
            if (k == 0) chk("slot", 5, slot_number);
        end
        cmd(24'h0f2200, 2, 24'h0f2300, 2);
        chk("ms loop", 0, ms_loop_closed);
        $display("multislot done");
    endtask
    task automatic t_audio;
        logic [2:0] d[5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
        logic [2:0] x[5] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h0};
        logic [31:0] r;
        for (int k = 0; k < 5; k++) begin
            cmd({16'h0f14, 5'h0, d[k]}, 3, 0, 0);
            chk("device", x[k], audio_device);
            chk("active", x[k] != 0, audio_test_active);
        end
        ahb(1, tlcd_pkg::REG_CTRL, 3, r);
        audio_port_device <= 3'h2;
        audio_port_strobe <= 1'b1;
        @(posedge hclk);
        audio_port_strobe <= 1'b0;
        cmd(24'h0f1401, 3, 0, 0);
        chk("device", 2, audio_device);
        $display("audio done");
    endtask
    task automatic results;
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_link();
        t_drop();
        t_loops();
        t_multi();
        t_audio();
        results();
    end
    initial begin
        #(100 * 20000);
        n_fail++;
        results();
    end
endmodule
`default_nettype wire

// ### bench/tlcd_tester.sv
// Tester model: sends test commands, collects acknowledgements
`timescale 1ns/1ns
`default_nettype none
module tlcd_tester (
    // Clock
    input wire logic hclk,
    // Commands
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    input wire logic rx_ready,
    // Acknowledgements
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    logic [7:0] got[$];
    logic slow = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h5a;
        rx_last = 1'b0;
        tx_ready = 1'b1;
    end
    // A busy tester is ready on every other cycle
    always @(posedge hclk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
        end
        tx_ready <= slow ? !tx_ready : 1'b1;
    end
    // Idle data flips so no stale octet lingers
    task automatic send(input logic [23:0] m, input int n);
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'b1;
            rx_data <= m[23-8*i -: 8];
            rx_last <= (i == n - 1);
            do @(posedge hclk); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~rx_data;
    endtask
endmodule
`default_nettype wire

// ### bench/tlcd_top_properties.sv
// Port checker for the test loop command decoder
`timescale 1ns/1ns
`default_nettype none
module tlcd_top_checker (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Acknowledgements
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_ready,
    // Link and loops
    input wire logic test_sim_present,
    input wire logic link_ready,
    input wire logic maintenance_test_link,
    input wire logic flow_on_msg,
    input wire logic traffic_loop_closed,
    input wire tlcd_pkg::tlcd_loop_e loop_kind,
    input wire logic ms_loop_closed,
    input wire logic [1:0] coding_select,
    input wire logic [2:0] ms_mech,
    input wire logic slot_number_valid
);
    logic mid;
    logic sent;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Frame position: only the header octet is fixed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mid <= 1'b0;
            sent <= 1'b0;
        end else begin
            if (tx_valid && tx_ready) begin
                mid <= !tx_last;
            end
            sent <= maintenance_test_link && (sent || flow_on_msg);
        end
    end
    sequence s_stall; tx_valid && !tx_ready; endsequence
    sequence s_held; tx_valid && $stable(tx_data) && $stable(tx_last); endsequence
    property p_hold; s_stall |=> s_held; endproperty
    a_hold: assert property (p_hold) else $error("ack octet changed while stalled");
    property p_hdr; tx_valid && !mid |-> tx_data == 8'h0f; endproperty
    a_hdr: assert property (p_hdr) else $error("bad ack header");
    property p_sim; $rose(maintenance_test_link) |-> $past(test_sim_present); endproperty
    a_sim: assert property (p_sim) else $error("link up without test card");
    property p_off; $fell(test_sim_present) |-> ##[1:3] !maintenance_test_link; endproperty
    a_off: assert property (p_off) else $error("link kept after card removal");
    property p_why; flow_on_msg |-> $past(maintenance_test_link) && $past(link_ready); endproperty
    a_why: assert property (p_why) else $error("flow-on without ready link");
    property p_once; flow_on_msg |-> !sent; endproperty
    a_once: assert property (p_once) else $error("second flow-on");
    property p_kind; traffic_loop_closed |-> loop_kind != tlcd_pkg::LOOP_NONE; endproperty
    a_kind: assert property (p_kind) else $error("closed loop without kind");
    property p_ms; ms_loop_closed |-> coding_select < 2'h2 && ms_mech < 3'h2; endproperty
    a_ms: assert property (p_ms) else $error("reserved multislot code used");
    property p_tn; ms_loop_closed |-> slot_number_valid == (ms_mech == 3'h0); endproperty
    a_tn: assert property (p_tn) else $error("slot use wrong for mechanism");
endmodule
bind tlcd_top tlcd_top_checker u_tlcd_top_checker (.*);
`default_nettype wire

// ### logic/tlcd_pkg.sv
// Shared constants and carriers for the test loop command decoder
package tlcd_pkg;
    // Test message header
    localparam logic [3:0] PD_TEST = 4'hf;
    localparam logic [3:0] SKIP_OK = 4'h0;
    localparam logic [3:0] SER_ML = 4'h2;
    // Message types
    localparam logic [7:0] MT_CLOSE_TL = 8'h00;
    localparam logic [7:0] MT_CLOSE_TL_ACK = 8'h01;
    localparam logic [7:0] MT_OPEN_TL = 8'h06;
    localparam logic [7:0] MT_OPEN_TL_ACK = 8'h07;
    localparam logic [7:0] MT_LINK_ACT = 8'h0c;
    localparam logic [7:0] MT_LINK_ACT_ACK = 8'h0d;
    localparam logic [7:0] MT_LINK_DEACT = 8'h10;
    localparam logic [7:0] MT_TEST_IF = 8'h14;
    localparam logic [7:0] MT_CLOSE_ML = 8'h20;
    localparam logic [7:0] MT_CLOSE_ML_ACK = 8'h21;
    localparam logic [7:0] MT_OPEN_ML = 8'h22;
    localparam logic [7:0] MT_OPEN_ML_ACK = 8'h23;
    // Optional acknowledge element of open traffic loop
    localparam logic [7:0] ACK_IE_MASK = 8'hf1;
    localparam logic [7:0] ACK_IE_VAL = 8'h81;
    // Loop type field layout and codes
    localparam int CHC_LSB = 0;
    localparam int MECH_LSB = 2;
    localparam int TN_LSB = 5;
    localparam logic [1:0] CHC_G = 2'h0;
    localparam logic [1:0] CHC_H = 2'h1;
    localparam logic [2:0] MECH_1 = 3'h0;
    localparam logic [2:0] MECH_2 = 3'h1;
    // Tested device codes
    localparam logic [2:0] DEV_NORMAL = 3'h0;
    localparam logic [2:0] DEV_DECODER = 3'h1;
    localparam logic [2:0] DEV_ENCODER = 3'h2;
    localparam logic [2:0] DEV_ACOUSTIC = 3'h4;
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DROPS = 8'h08;
    localparam int CTRL_AUDIO_PORT = 0;
    localparam int CTRL_POWER = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;
    localparam int ST_KIND_LSB = 3;

    typedef enum logic [2:0] {
        LOOP_A, LOOP_B, LOOP_C, LOOP_D, LOOP_E, LOOP_F, LOOP_I, LOOP_NONE
    } tlcd_loop_e;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h0, TX_SEND = 2'h1
    } tlcd_tx_state_e;

    // Parsed or outgoing message: index of last octet (octet count minus one), type, one argument
    typedef struct packed {
        logic [1:0] len;
        logic [7:0] mtype;
        logic [7:0] arg;
    } tlcd_msg_s;
endpackage

// ### logic/tlcd_rx_parser.sv
// Collects received test message octets and screens the header
`timescale 1ns/1ns
`default_nettype none
module tlcd_rx_parser (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Octet stream
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    // Parsed message
    output tlcd_pkg::tlcd_msg_s msg,
    output logic msg_valid,
    output logic drop
);
    logic [1:0] cnt;
    logic hdr_bad;
    logic take;
    logic [7:0] mt;
    logic ser_ok;

    assign take = rx_valid & rx_ready;
    assign mt = (cnt == 2'h1) ? rx_data : msg.mtype;
    // Series 0, 1 and 2 only
    assign ser_ok = (mt[7:4] <= tlcd_pkg::SER_ML);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 2'h0;
            hdr_bad <= 1'b0;
            msg <= '0;
            msg_valid <= 1'b0;
            drop <= 1'b0;
        end else if (ce) begin
            msg_valid <= 1'b0;
            drop <= 1'b0;
            if (take) begin
                if (cnt == 2'h0) begin
                    // Skip indicator high nibble, discriminator low
                    hdr_bad <= (rx_data[7:4] != tlcd_pkg::SKIP_OK)
                        || (rx_data[3:0] != tlcd_pkg::PD_TEST);
                    msg.arg <= 8'h00;
                end
                if (cnt == 2'h1) begin
                    msg.mtype <= rx_data;
                end
                if (cnt == 2'h2) begin
                    msg.arg <= rx_data;
                end
                // Octets past the third are ignored
                if (cnt != 2'h3) begin
                    msg.len <= cnt;
                end
                if (rx_last) begin
                    cnt <= 2'h0;
                    if (cnt != 2'h0 && !hdr_bad && ser_ok) begin
                        msg_valid <= 1'b1;
                    end else begin
                        drop <= 1'b1;
                    end
                end else if (cnt != 2'h3) begin
                    cnt <= cnt + 2'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### logic/tlcd_top.sv
// Test loop command decoder: link, audio test and loop control
// Function
// - Drop messages whose skip indicator is nonzero
// - Accept discriminator 1111, drop type series above 2
// - Bit X selects half-rate sub-channel one
// - Bits C..Y pick loop A-I, dashes ignored
// - Open loop may carry acknowledge element 0x81
// - Coding field 00 loop G, 01 loop H
// - Mechanism 000 is one, 001 is two
// - Timeslot used only under mechanism one
// - Multislot ack carries error indication bit
// - Activate link only with test SIM present
// - Send exactly one flow-on once link ready
// - Deactivate on power-off, removal, command; no flow-off
// - Acknowledge link activation command
// - Never acknowledge link deactivation command
// - New audio test function replaces the old
// - Device only takes commands, only sends acks
// - Decode tested device field, ignore reserved
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module tlcd_top (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Received test messages
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic rx_ready,
    // Transmitted acknowledgements
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    // Maintenance test link
    input wire logic test_sim_present,
    input wire logic link_ready,
    output logic maintenance_test_link,
    output logic flow_on_msg,
    // Audio test port
    input wire logic audio_port_strobe,
    input wire logic [2:0] audio_port_device,
    output logic [2:0] audio_device,
    output logic audio_test_active,
    // Traffic channel loops
    output logic traffic_loop_closed,
    output logic traffic_subch,
    output tlcd_pkg::tlcd_loop_e loop_kind,
    output logic ms_loop_closed,
    output logic [1:0] coding_select,
    output logic [2:0] ms_mech,
    output logic [2:0] slot_number,
    output logic slot_number_valid,
    output logic ms_error
);
    tlcd_pkg::tlcd_msg_s msg;
    tlcd_pkg::tlcd_msg_s tx_frame;
    logic msg_valid;
    logic parse_drop;
    logic tx_busy;
    logic tx_send;
    logic [1:0] ctrl;
    logic [7:0] drops;
    logic ap_write;
    logic [7:0] ap_addr;
    logic sim_q;
    logic power_q;
    logic flow_sent;
    logic link_ok;
    logic unknown;
    tlcd_pkg::tlcd_loop_e next_kind;
    logic ml_err;
    logic [1:0] chc_f;
    logic [2:0] mech_f;

    function automatic logic dev_ok(input logic [2:0] d);
        return d == tlcd_pkg::DEV_NORMAL || d == tlcd_pkg::DEV_DECODER
            || d == tlcd_pkg::DEV_ENCODER || d == tlcd_pkg::DEV_ACOUSTIC;
    endfunction

    function automatic tlcd_pkg::tlcd_msg_s ack1(input logic [7:0] mt);
        return '{len: 2'h1, mtype: mt, arg: 8'h00};
    endfunction

    // Octets wait while an answer is pending; no answer is ever lost
    assign rx_ready = !tx_busy && !tx_send && !msg_valid;
    assign link_ok = ctrl[tlcd_pkg::CTRL_POWER] && test_sim_present;
    assign chc_f = msg.arg[tlcd_pkg::CHC_LSB +: 2];
    assign mech_f = msg.arg[tlcd_pkg::MECH_LSB +: 3];
    // Valid codes are the lowest ones, so one compare screens the rest
    assign ml_err = (msg.len != 2'h2) || (chc_f > tlcd_pkg::CHC_H)
        || (mech_f > tlcd_pkg::MECH_2);

    tlcd_rx_parser u_parser (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .rx_valid(rx_valid),
        .rx_ready(rx_ready),
        .rx_data(rx_data),
        .rx_last(rx_last),
        .msg(msg),
        .msg_valid(msg_valid),
        .drop(parse_drop)
    );

    tlcd_tx_framer u_framer (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .send(tx_send),
        .frame(tx_frame),
        .busy(tx_busy),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .tx_last(tx_last),
        .tx_ready(tx_ready)
    );

    // Don't-care positions fall out of the casez wildcards
    always_comb begin
        casez (msg.arg[5:1])
            5'b00000: next_kind = tlcd_pkg::LOOP_A;
            5'b00001: next_kind = tlcd_pkg::LOOP_B;
            5'b0001?: next_kind = tlcd_pkg::LOOP_C;
            5'b001??: next_kind = tlcd_pkg::LOOP_D;
            5'b010??: next_kind = tlcd_pkg::LOOP_E;
            5'b011??: next_kind = tlcd_pkg::LOOP_F;
            5'b111??: next_kind = tlcd_pkg::LOOP_I;
            default: next_kind = tlcd_pkg::LOOP_NONE;
        endcase
    end

    // Command decode and answer build
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_send <= 1'b0;
            tx_frame <= '0;
            traffic_loop_closed <= 1'b0;
            traffic_subch <= 1'b0;
            loop_kind <= tlcd_pkg::LOOP_NONE;
            ms_loop_closed <= 1'b0;
            coding_select <= tlcd_pkg::CHC_G;
            ms_mech <= tlcd_pkg::MECH_1;
            slot_number <= 3'h0;
            slot_number_valid <= 1'b0;
            ms_error <= 1'b0;
            unknown <= 1'b0;
        end else if (ce) begin
            tx_send <= 1'b0;
            unknown <= 1'b0;
            if (msg_valid) begin
                case (msg.mtype)
                    tlcd_pkg::MT_CLOSE_TL: begin
                        if (msg.len == 2'h2 && next_kind != tlcd_pkg::LOOP_NONE) begin
                            traffic_loop_closed <= 1'b1;
                            traffic_subch <= msg.arg[0];
                            loop_kind <= next_kind;
                            tx_frame <= ack1(tlcd_pkg::MT_CLOSE_TL_ACK);
                            tx_send <= 1'b1;
                        end else begin
                            unknown <= 1'b1;
                        end
                    end
                    tlcd_pkg::MT_OPEN_TL: begin
                        traffic_loop_closed <= 1'b0;
                        loop_kind <= tlcd_pkg::LOOP_NONE;
                        if (msg.len == 2'h2
                            && (msg.arg & tlcd_pkg::ACK_IE_MASK) == tlcd_pkg::ACK_IE_VAL) begin
                            tx_frame <= ack1(tlcd_pkg::MT_OPEN_TL_ACK);
                            tx_send <= 1'b1;
                        end
                    end
                    tlcd_pkg::MT_CLOSE_ML: begin
                        ms_error <= ml_err;
                        if (!ml_err) begin
                            ms_loop_closed <= 1'b1;
                            coding_select <= chc_f;
                            ms_mech <= mech_f;
                            slot_number <= msg.arg[tlcd_pkg::TN_LSB +: 3];
                            slot_number_valid <= (mech_f == tlcd_pkg::MECH_1);
                        end
                        // Result echoes mechanism and coding, error in bit 0
                        tx_frame <= '{len: 2'h2, mtype: tlcd_pkg::MT_CLOSE_ML_ACK,
                            arg: {mech_f, chc_f, 2'h0, ml_err}};
                        tx_send <= 1'b1;
                    end
                    tlcd_pkg::MT_OPEN_ML: begin
                        ms_loop_closed <= 1'b0;
                        slot_number_valid <= 1'b0;
                        tx_frame <= ack1(tlcd_pkg::MT_OPEN_ML_ACK);
                        tx_send <= 1'b1;
                    end
                    tlcd_pkg::MT_LINK_ACT: begin
                        if (link_ok) begin
                            tx_frame <= ack1(tlcd_pkg::MT_LINK_ACT_ACK);
                            tx_send <= 1'b1;
                        end
                    end
                    tlcd_pkg::MT_LINK_DEACT: begin
                        tx_send <= 1'b0;
                    end
                    tlcd_pkg::MT_TEST_IF: begin
                        unknown <= (msg.len != 2'h2);
                    end
                    default: begin
                        // Received acks and other unlisted types of series 0 to 2 come this way
                        unknown <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Maintenance test link activation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sim_q <= 1'b0;
            power_q <= 1'b0;
            maintenance_test_link <= 1'b0;
        end else if (ce) begin
            sim_q <= test_sim_present;
            power_q <= ctrl[tlcd_pkg::CTRL_POWER];
            if (!link_ok) begin
                maintenance_test_link <= 1'b0;
            end else if (msg_valid && msg.mtype == tlcd_pkg::MT_LINK_DEACT) begin
                maintenance_test_link <= 1'b0;
            end else if (!power_q || !sim_q
                || (msg_valid && msg.mtype == tlcd_pkg::MT_LINK_ACT)) begin
                maintenance_test_link <= 1'b1;
            end
        end
    end

    // One flow-on per activation; deactivation sends nothing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flow_sent <= 1'b0;
            flow_on_msg <= 1'b0;
        end else if (ce) begin
            flow_on_msg <= 1'b0;
            if (!maintenance_test_link) begin
                flow_sent <= 1'b0;
            end else if (link_ready && !flow_sent) begin
                flow_on_msg <= 1'b1;
                flow_sent <= 1'b1;
            end
        end
    end

    // Audio test selection: message or port, per control bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            audio_device <= tlcd_pkg::DEV_NORMAL;
        end else if (ce) begin
            if (ctrl[tlcd_pkg::CTRL_AUDIO_PORT]) begin
                if (audio_port_strobe && dev_ok(audio_port_device)) begin
                    audio_device <= audio_port_device;
                end
            end else if (msg_valid && msg.mtype == tlcd_pkg::MT_TEST_IF
                && msg.len == 2'h2 && dev_ok(msg.arg[2:0])) begin
                audio_device <= msg.arg[2:0];
            end
        end
    end

    assign audio_test_active = (audio_device != tlcd_pkg::DEV_NORMAL);

    // Discarded message counter, saturating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drops <= 8'h00;
        end else if (ce) begin
            if ((parse_drop || unknown) && drops != 8'hff) begin
                drops <= drops + 8'h01;
            end
        end
    end

    // AHB-Lite: zero wait states, stalls only while frozen
    assign hreadyout = ce;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
            ctrl <= tlcd_pkg::CTRL_RESET;
            hrdata <= '0;
        end else if (ce) begin
            if (ap_write && ap_addr == tlcd_pkg::REG_CTRL) begin
                ctrl <= hwdata[1:0];
            end
            ap_write <= hsel && hready && htrans[1] && hwrite;
            ap_addr <= {haddr[7:2], 2'h0};
            hrdata <= '0;
            if (hsel && hready && htrans[1] && !hwrite && haddr[31:8] == 24'h00_0000) begin
                case ({haddr[7:2], 2'h0})
                    tlcd_pkg::REG_CTRL: hrdata <= {30'h0, ctrl};
                    tlcd_pkg::REG_STATUS: hrdata <= {13'h0, ms_error, audio_device,
                        slot_number, ms_mech, coding_select, ms_loop_closed,
                        loop_kind, traffic_subch, traffic_loop_closed,
                        maintenance_test_link};
                    tlcd_pkg::REG_DROPS: hrdata <= {24'h0, drops};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ### logic/tlcd_tx_framer.sv
// Serialises one outgoing test message with its header octet
`timescale 1ns/1ns
`default_nettype none
module tlcd_tx_framer (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Request
    input wire logic send,
    input wire tlcd_pkg::tlcd_msg_s frame,
    output logic busy,
    // Octet stream
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready
);
    tlcd_pkg::tlcd_tx_state_e state;
    tlcd_pkg::tlcd_msg_s held;
    logic [1:0] idx;

    assign busy = (state != tlcd_pkg::TX_IDLE);
    assign tx_valid = (state == tlcd_pkg::TX_SEND);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= tlcd_pkg::TX_IDLE;
            held <= '0;
            idx <= 2'h0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
        end else if (ce) begin
            case (state)
                tlcd_pkg::TX_IDLE: begin
                    if (send) begin
                        held <= frame;
                        idx <= 2'h1;
                        tx_data <= {tlcd_pkg::SKIP_OK, tlcd_pkg::PD_TEST};
                        tx_last <= 1'b0;
                        state <= tlcd_pkg::TX_SEND;
                    end
                end
                tlcd_pkg::TX_SEND: begin
                    if (tx_ready) begin
                        if (tx_last) begin
                            state <= tlcd_pkg::TX_IDLE;
                            tx_last <= 1'b0;
                        end else begin
                            tx_data <= (idx == 2'h1) ? held.mtype : held.arg;
                            tx_last <= (idx == held.len);
                            idx <= idx + 2'h1;
                        end
                    end
                end
                default: begin
                    state <= tlcd_pkg::TX_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire
